/* timer_pulse_measure_and_pwm_tb.sv */
// Self-checking bench for the timer pulse measure and PWM block.
// Assumes package, design, partner model and checker compiled before it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
    mismatches++; $display("ERROR %0t: got %0h exp %0h", $time, g, e); \
    end end

module timer_pulse_measure_and_pwm_tb;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic sleep = 1'b0;
    logic psc_on = 1'b1;
    logic idle_lvl = 1'b1;
    logic start = 1'b0;
    logic clr = 1'b0;
    logic [15:0] width = 16'h0000;
    logic pin, irq, wake, p_out, n_out;
    logic [7:0] rdata;
    logic [15:0] hi_cnt;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    int irqs = 0;
    int wakes = 0;
    int dn [8] = '{1, 2, 3, 4, 8, 16, 32, 64};

    tpm_timer_pwm i_dut (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .sleep_i(sleep), .psc_active_i(psc_on),
        .timer_input_pin_i(pin), .timer_irq_o(irq), .wake_req_o(wake),
        .pwm_out_primary_o(p_out), .pwm_out_inverse_o(n_out)
    );
    tpm_partner i_far (
        .mclk_i(mclk_i), .idle_lvl_i(idle_lvl), .start_i(start),
        .width_i(width), .pwm_i(p_out), .clr_i(clr), .pin_o(pin),
        .hi_cnt_o(hi_cnt)
    );

    // Free-running system clock, 8 ns period.
    initial begin
        forever #4 mclk_i = ~mclk_i;
    end

    // Cycle ceiling and event counting; a hang ends in the report.
    always @(posedge mclk_i) begin
        cycles++;
        if (irq === 1'b1) irqs++;
        if (wake === 1'b1) wakes++;
        if (cycles == 99000) begin
            mismatches++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    // An idle edge after each access keeps strobes from being reassigned.
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk_i);
        wr <= 1'b0;
        @(posedge mclk_i);
    endtask

    task automatic rd_reg(input logic [1:0] a, output logic [7:0] v);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk_i);
        rd <= 1'b0;
        #1;
        v = rdata;
        @(posedge mclk_i);
    endtask

    task automatic pulse(input int w);
        width <= 16'(w);
        start <= 1'b1;
        @(posedge mclk_i);
        start <= 1'b0;
        tick(w + 2);
    endtask

    task automatic t_regs();
        logic [7:0] v;
        rd_reg(2'h2, v);
        `CHK(v, 8'h01)
        wr_reg(2'h0, 8'hff);
        rd_reg(2'h0, v);
        `CHK(v, 8'hdf)
        rd_reg(2'h2, v);
        `CHK(v, 8'h02)
        wr_reg(2'h0, 8'h00);
        wr_reg(2'h3, 8'h55);
        rd_reg(2'h3, v);
        `CHK(v, 8'h00)
        $display("test regs done");
    endtask

    // Arms with the pin resting at the active level, then a stop-type edge.
    task automatic t_meas(input logic eg, input logic [2:0] ps,
            input logic [7:0] pl, input int w, input logic [7:0] lo, hi);
        logic [7:0] v, c;
        idle_lvl <= eg;
        wr_reg(2'h0, 8'hc0);
        wr_reg(2'h1, pl);
        wr_reg(2'h0, {4'hd, eg, ps});
        tick(4);
        rd_reg(2'h2, v);
        `CHK(v, 8'h02)
        idle_lvl <= !eg;
        tick(3);
        rd_reg(2'h2, v);
        `CHK(v, 8'h02)
        pulse(w);
        tick(4);
        rd_reg(2'h0, v);
        `CHK(v, {4'hc, eg, ps})
        rd_reg(2'h1, c);
        `CHK(c >= lo && c <= hi, 1'b1)
        pulse(w);
        rd_reg(2'h1, v);
        `CHK(v, c)
        rd_reg(2'h2, v);
        `CHK(v, 8'h01)
        $display("test measure done");
    endtask

    task automatic t_keep(input logic [7:0] cv);
        logic [7:0] v;
        wr_reg(2'h0, cv);
        pulse(6);
        pulse(6);
        rd_reg(2'h0, v);
        `CHK(v, cv)
        $display("test run kept done");
    endtask

    // Stalls the prescaler clock mid-pulse; counting must pause with it.
    task automatic t_gate();
        logic [7:0] v;
        idle_lvl <= 1'b1;
        wr_reg(2'h0, 8'hc0);
        wr_reg(2'h1, 8'h00);
        wr_reg(2'h0, 8'hd0);
        tick(4);
        fork
            pulse(40);
            begin
                tick(11);
                psc_on <= 1'b0;
                tick(20);
                psc_on <= 1'b1;
            end
        join
        rd_reg(2'h1, v);
        `CHK(v >= 8'd16 && v <= 8'd20, 1'b1)
        rd_reg(2'h2, v);
        `CHK(v, 8'h01)
        $display("test clock stall done");
    endtask

    // Any window of one full PWM cycle holds the whole duty, at any phase.
    task automatic t_pwm(input logic fm, input logic [2:0] dv,
            input logic [7:0] d, input int n);
        wr_reg(2'h0, {3'h0, dv, fm, 1'b0});
        wr_reg(2'h1, d);
        wr_reg(2'h0, {3'h0, dv, fm, 1'b1});
        tick(256 * n + 1100);
        clr <= 1'b1;
        @(posedge mclk_i);
        clr <= 1'b0;
        tick(256 * n);
        #1;
        `CHK(hi_cnt, 16'(d * n))
        $display("test pwm done");
    endtask

    initial begin
        tick(10);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        t_regs();
        t_meas(1'b0, 3'h0, 8'h00, 40, 8'd36, 8'd41);
        t_meas(1'b1, 3'h2, 8'h00, 100, 8'd22, 8'd27);
        sleep <= 1'b1;
        irqs = 0;
        wakes = 0;
        t_meas(1'b0, 3'h0, 8'hf0, 25, 8'hf5, 8'hfa);
        `CHK(irqs, 1)
        `CHK(wakes, 1)
        sleep <= 1'b0;
        t_keep(8'h90);
        t_keep(8'h50);
        t_gate();
        t_pwm(1'b0, 3'h0, 8'h9b, 1);
        t_pwm(1'b1, 3'h0, 8'h9b, 1);
        t_pwm(1'b0, 3'h0, 8'h00, 1);
        t_pwm(1'b1, 3'h0, 8'hff, 1);
        for (int k = 1; k < 8; k++) begin
            t_pwm(1'b0, 3'(k), 8'h45, dn[k]);
        end
        wr_reg(2'h0, 8'h00);
        tick(3);
        `CHK(p_out, 1'b0)
        `CHK(n_out, 1'b1)
        close_out();
    end
endmodule

`default_nettype wire

/* tpm_cfg.svh */
// Constants for the pulse measure and PWM timer block.
// Assumes inclusion by bare name from the package; the design modules use its macros without including it.
`ifndef TPM_CFG_SVH
`define TPM_CFG_SVH

// Register word offsets on the plain register port.
`define TPM_OFS_CTRL 2'h0
`define TPM_OFS_DATA 2'h1
`define TPM_OFS_STAT 2'h2

// Control register field positions.
`define TPM_MODE_HI 7
`define TPM_MODE_LO 6
`define TPM_RUN_BIT 4
`define TPM_EDGE_BIT 3
`define TPM_PSC_HI 2
`define TPM_PSC_LO 0
`define TPM_DIV_HI 4
`define TPM_DIV_LO 2
`define TPM_FMT_BIT 1
`define TPM_PEN_BIT 0

// Control register writable mask; bit 5 is unimplemented and reads zero.
`define TPM_CTRL_MASK 8'hdf

// Reset values.
`define TPM_CTRL_RST 8'h00
`define TPM_DUTY_RST 8'h00
`define TPM_PRELOAD_RST 8'h00
`define TPM_COUNT_RST 8'h00

// Operating mode codes.
`define TPM_MODE_PWM 2'h0
`define TPM_MODE_EVT 2'h1
`define TPM_MODE_TMR 2'h2
`define TPM_MODE_PWMEAS 2'h3

// Full count of the eight-bit counter.
`define TPM_COUNT_MAX 8'hff

`endif

/* tpm_chk.sv */
// Port-level properties for the timer pulse measure and PWM block.
// Assumes one clock, mclk_i, and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module tpm_chk (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Register port and power state.
    input wire logic [1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic sleep_i,
    // Watched outputs.
    input wire logic timer_irq_o,
    input wire logic wake_req_o,
    input wire logic pwm_out_primary_o,
    input wire logic pwm_out_inverse_o
);
    logic [7:0] ctl_sh;
    logic [7:0] duty_sh;
    logic [9:0] quiet;
    logic [7:0] hi_len;
    logic [6:0] crs;
    logic full;
    logic cmid;
    logic div0;
    logic pwm_on;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    // Shadow the setup; duty only lands while the mode field selects PWM.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            ctl_sh <= 8'h00;
            duty_sh <= 8'h00;
        end else if (reg_wr_i && reg_addr_i == 2'h0) begin
            ctl_sh <= reg_wdata_i & 8'hdf;
        end else if (reg_wr_i && reg_addr_i == 2'h1 && ctl_sh[7:6] == 2'h0) begin
            duty_sh <= reg_wdata_i;
        end
    end

    // Cycles since any write; the first PWM cycle after one may be irregular.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || reg_wr_i) begin
            quiet <= 10'h000;
        end else if (quiet != 10'h3ff) begin
            quiet <= quiet + 10'h001;
        end
    end

    // Length of the running high phase of the primary output.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || !pwm_out_primary_o) begin
            hi_len <= 8'h00;
        end else begin
            hi_len <= hi_len + 8'h01;
        end
    end

    // Coarse part of the duty for the selected format.
    assign crs = ctl_sh[1] ? duty_sh[7:1] : {1'b0, duty_sh[7:2]};
    assign full = ctl_sh[1] ? crs == 7'h7f : crs == 7'h3f;
    assign cmid = crs != 7'h00 && !full;
    assign div0 = ctl_sh[4:2] == 3'h0;
    assign pwm_on = ctl_sh[7:6] == 2'h0 && ctl_sh[0] && quiet > 10'h380;

    property p_inv;
        pwm_out_inverse_o == !pwm_out_primary_o;
    endproperty
    a_inv: assert property (p_inv)
        else $error("PWM pair not complementary");

    property p_wake;
        wake_req_o |-> timer_irq_o && $past(sleep_i);
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake request without overflow in sleep");

    property p_off;
        ctl_sh[7:6] == 2'h0 && !ctl_sh[0] && quiet > 10'h001
            |-> !pwm_out_primary_o;
    endproperty
    a_off: assert property (p_off)
        else $error("primary output high while disabled");

    property p_zero;
        pwm_on && duty_sh == 8'h00 |-> !pwm_out_primary_o;
    endproperty
    a_zero: assert property (p_zero)
        else $error("primary output high with zero duty");

    property p_per62;
        pwm_on && div0 && !ctl_sh[1] && cmid && $rose(pwm_out_primary_o)
            |-> ##64 ($rose(pwm_out_primary_o) || quiet < 10'h040);
    endproperty
    a_per62: assert property (p_per62)
        else $error("six-plus-two sub-cycle not 64 clocks");

    property p_per71;
        pwm_on && div0 && ctl_sh[1] && cmid && $rose(pwm_out_primary_o)
            |-> ##128 ($rose(pwm_out_primary_o) || quiet < 10'h080);
    endproperty
    a_per71: assert property (p_per71)
        else $error("seven-plus-one sub-cycle not 128 clocks");

    property p_div1;
        pwm_on && ctl_sh[4:2] == 3'h1 && !ctl_sh[1] && cmid
            && $rose(pwm_out_primary_o)
            |-> ##128 ($rose(pwm_out_primary_o) || quiet < 10'h080);
    endproperty
    a_div1: assert property (p_div1)
        else $error("divide-by-two sub-cycle not 128 clocks");

    property p_hi;
        pwm_on && div0 && !full && $fell(pwm_out_primary_o)
            |-> hi_len == {1'b0, crs} || hi_len == {1'b0, crs} + 8'h01;
    endproperty
    a_hi: assert property (p_hi)
        else $error("high phase differs from coarse duty");
endmodule

bind tpm_timer_pwm tpm_chk i_chk (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .sleep_i(sleep_i),
    .timer_irq_o(timer_irq_o), .wake_req_o(wake_req_o),
    .pwm_out_primary_o(pwm_out_primary_o),
    .pwm_out_inverse_o(pwm_out_inverse_o)
);

`default_nettype wire

/* tpm_partner.sv */
// Far side: a pulse source on the timer input and a load on the primary PWM output.
// Assumes start_i is a one-cycle pulse raised just after a rising edge.
`timescale 1ns/1ps
`default_nettype none

module tpm_partner (
    // Clock.
    input wire logic mclk_i,
    // Pulse request.
    input wire logic idle_lvl_i,
    input wire logic start_i,
    input wire logic [15:0] width_i,
    // Load side.
    input wire logic pwm_i,
    input wire logic clr_i,
    // Outputs.
    output logic pin_o,
    output logic [15:0] hi_cnt_o
);
    logic [15:0] left = 16'h0000;

    // The pin rests at the idle level and leaves it for width_i cycles.
    always_ff @(posedge mclk_i) begin
        if (start_i) begin
            left <= width_i;
        end else if (left != 16'h0000) begin
            left <= left - 16'h0001;
        end
    end
    assign pin_o = (left != 16'h0000) ? !idle_lvl_i : idle_lvl_i;

    // The load integrates high time, as a buzzer averages its drive.
    always_ff @(posedge mclk_i) begin
        if (clr_i) begin
            hi_cnt_o <= 16'h0000;
        end else if (pwm_i) begin
            hi_cnt_o <= hi_cnt_o + 16'h0001;
        end
    end
endmodule

`default_nettype wire

/* tpm_pkg.sv */
// Types shared by the pulse measure and PWM timer block.
// Assumes tpm_cfg.svh is reachable on the include path.
`include "tpm_cfg.svh"

package tpm_pkg;

    // Operating mode held in the two top control bits.
    typedef enum logic [1:0] {
        TPM_OP_PWM = `TPM_MODE_PWM,
        TPM_OP_EVT = `TPM_MODE_EVT,
        TPM_OP_TMR = `TPM_MODE_TMR,
        TPM_OP_PWMEAS = `TPM_MODE_PWMEAS
    } tpm_mode_t;

    // Pulse measurement sequencer states, one-hot.
    typedef enum logic [2:0] {
        TPM_ST_IDLE = 3'b001,
        TPM_ST_ARMED = 3'b010,
        TPM_ST_COUNT = 3'b100
    } tpm_state_t;

    // One register access as seen on the plain register port.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [1:0] addr;
        logic [7:0] wdata;
    } tpm_req_t;

endpackage

/* tpm_tick_gen.sv */
// Programmable tick generator: one pulse every ratio clocks.
// Assumes ratio is at least one and stable while enabled.
`timescale 1ns/1ps
`default_nettype none

module tpm_tick_gen #(
    parameter int RW = 8
) (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Control.
    input wire logic en_i,
    input wire logic [RW-1:0] ratio_i,
    // Tick out.
    output logic tick_o
);

    logic [RW-1:0] cnt_reg;

    // Count up to ratio minus one, then wrap and pulse; restart when idle.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || !en_i) begin
            cnt_reg <= '0;
            tick_o <= 1'b0;
        end else if (cnt_reg >= ratio_i - RW'(1)) begin
            cnt_reg <= '0;
            tick_o <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + RW'(1);
            tick_o <= 1'b0;
        end
    end

endmodule

`default_nettype wire

/* tpm_timer_pwm.sv */
// Eight-bit timer in pulse width measurement mode and a PWM generator.
// Assumes the timer input is synchronous to mclk_i and that the register
// port master keeps strobes one cycle long and never both at once.
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Control mode field 11 selects pulse width measurement.
// - Measurement counts prescaled internal clock, ratio from prescale field.
// - After run bit set, wait idle for the active input edge.
// - Edge bit low: falling starts, rising stops; high: the reverse.
// - Input return to original level clears run bit, stops counter.
// - In timer and event modes hardware never clears run bit.
// - Counter holds final value after measurement for software to read.
// - Run bit clear ignores input; software re-arms each single shot.
// - Start and stop come from detected input transitions, not levels.
// - Overflow raises interrupt, reloads from preload, keeps counting.
// - In idle or sleep, measuring continues; overflow also requests wake.
// - Control mode field 00 selects PWM operation.
// - Eight-bit duty sets total high time, spread over sub-cycles.
// - Second PWM output is always the inverse of the primary.
// - PWM cycle 256 clocks; sub-cycle 128 or 64 clocks by format.
// - Six-plus-two: four 64-clock sub-cycles, coarse plus one when below fine.
// - Seven-plus-one: two 128-clock sub-cycles, coarse bits 7..1, fine bit 0.
// - PWM divider codes 0..7 divide system clock by 1,2,3,4,8,16,32,64.
// - With PWM enable clear, the primary PWM signal is held low.
// - Duty writes act at once; one PWM cycle may be irregular.
module tpm_timer_pwm
    import tpm_pkg::*;
#(
    parameter int DIV_W = 8
) (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Register port.
    input wire logic [1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // Power state and prescaler clock presence.
    input wire logic sleep_i,
    input wire logic psc_active_i,
    // Timer input pin.
    input wire logic timer_input_pin_i,
    // Events.
    output logic timer_irq_o,
    output logic wake_req_o,
    // PWM pair.
    output logic pwm_out_primary_o,
    output logic pwm_out_inverse_o
);

    // Prescale ratio is 2 to the power of the selection code.
    function automatic logic [DIV_W-1:0] psc_ratio(input logic [2:0] sel);
        psc_ratio = DIV_W'(1) << sel;
    endfunction

    // PWM clock ratio table for the divider field.
    function automatic logic [DIV_W-1:0] pwm_ratio(input logic [2:0] sel);
        case (sel)
            3'h0: pwm_ratio = DIV_W'(1);
            3'h1: pwm_ratio = DIV_W'(2);
            3'h2: pwm_ratio = DIV_W'(3);
            3'h3: pwm_ratio = DIV_W'(4);
            3'h4: pwm_ratio = DIV_W'(8);
            3'h5: pwm_ratio = DIV_W'(16);
            3'h6: pwm_ratio = DIV_W'(32);
            default: pwm_ratio = DIV_W'(64);
        endcase
    endfunction

    // Registers and state.
    tpm_req_t req;
    logic [7:0] ctrl_reg;
    logic [7:0] duty_reg;
    logic [7:0] preload_reg;
    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic pin_prev_reg;
    logic [7:0] pwm_cnt_reg;
    tpm_state_t state_reg;
    tpm_state_t state_next;

    // Decoded control fields.
    tpm_mode_t mode;
    logic run_bit;
    logic edge_sel;
    logic [2:0] psc_sel;
    logic [2:0] div_sel;
    logic fmt_sel;
    logic pwm_en;
    logic pwm_active;
    logic meas_mode;

    // Edge and tick events.
    logic pin_rise;
    logic pin_fall;
    logic start_edge;
    logic stop_edge;
    logic psc_tick;
    logic pwm_tick;
    logic count_step;
    logic overflow;
    logic hw_clear_run;
    logic ctrl_wr;
    logic data_wr;

    // PWM shaping.
    logic [7:0] sub_pos;
    logic [7:0] sub_high;
    logic pwm_high;

    assign req = '{wr: reg_wr_i, rd: reg_rd_i, addr: reg_addr_i,
                   wdata: reg_wdata_i};
    assign ctrl_wr = req.wr && (req.addr == `TPM_OFS_CTRL);
    assign data_wr = req.wr && (req.addr == `TPM_OFS_DATA);

    // Control fields share bits by mode, exactly as the register overlays.
    assign mode = tpm_mode_t'(ctrl_reg[`TPM_MODE_HI:`TPM_MODE_LO]);
    assign run_bit = ctrl_reg[`TPM_RUN_BIT];
    assign edge_sel = ctrl_reg[`TPM_EDGE_BIT];
    assign psc_sel = ctrl_reg[`TPM_PSC_HI:`TPM_PSC_LO];
    assign div_sel = ctrl_reg[`TPM_DIV_HI:`TPM_DIV_LO];
    assign fmt_sel = ctrl_reg[`TPM_FMT_BIT];
    assign pwm_en = ctrl_reg[`TPM_PEN_BIT];
    assign meas_mode = (mode == TPM_OP_PWMEAS);
    assign pwm_active = (mode == TPM_OP_PWM) && pwm_en;

    // Transitions are found by comparing with last cycle's pin level, so a
    // pin already sitting at the start level never starts a measurement.
    assign pin_rise = timer_input_pin_i && !pin_prev_reg;
    assign pin_fall = !timer_input_pin_i && pin_prev_reg;
    assign start_edge = edge_sel ? pin_rise : pin_fall;
    assign stop_edge = edge_sel ? pin_fall : pin_rise;

    // Prescaled count clock; it only runs while the internal clock source
    // is alive, which is what lets a measurement go on through sleep.
    tpm_tick_gen #(
        .RW(DIV_W)
    ) u_psc (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .en_i(meas_mode && psc_active_i && (state_reg == TPM_ST_COUNT)),
        .ratio_i(psc_ratio(psc_sel)),
        .tick_o(psc_tick)
    );

    // PWM clock divider.
    tpm_tick_gen #(
        .RW(DIV_W)
    ) u_pwmdiv (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .en_i(pwm_active),
        .ratio_i(pwm_ratio(div_sel)),
        .tick_o(pwm_tick)
    );

    assign count_step = (state_reg == TPM_ST_COUNT) && psc_tick &&
                        psc_active_i;
    assign overflow = count_step && (count_reg == `TPM_COUNT_MAX);
    // Only the measurement sequencer ever clears the run bit by itself.
    assign hw_clear_run = meas_mode && (state_reg == TPM_ST_COUNT) &&
                          run_bit && stop_edge;

    // Sequencer: armed waits for the start edge, counting waits for the
    // stop edge. Any state falls back to idle once the run bit is gone.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            TPM_ST_IDLE: begin
                if (meas_mode && run_bit) begin
                    state_next = TPM_ST_ARMED;
                end
            end
            TPM_ST_ARMED: begin
                if (!meas_mode || !run_bit) begin
                    state_next = TPM_ST_IDLE;
                end else if (start_edge) begin
                    state_next = TPM_ST_COUNT;
                end
            end
            TPM_ST_COUNT: begin
                if (!meas_mode || !run_bit || stop_edge) begin
                    state_next = TPM_ST_IDLE;
                end
            end
            default: begin
                state_next = TPM_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state_reg <= TPM_ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Previous pin level for the transition detectors. It resets low, so a
    // pin resting high shows one false rise right after reset; that is
    // harmless, since the run bit resets clear and no edge is watched yet.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            pin_prev_reg <= 1'b0;
        end else begin
            pin_prev_reg <= timer_input_pin_i;
        end
    end

    // Control register. A software write in the same cycle as the automatic
    // clear wins, so a re-arm issued right at the stop edge is not lost.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            ctrl_reg <= `TPM_CTRL_RST;
        end else if (ctrl_wr) begin
            ctrl_reg <= req.wdata & `TPM_CTRL_MASK;
        end else if (hw_clear_run) begin
            ctrl_reg[`TPM_RUN_BIT] <= 1'b0;
        end
    end

    // The data offset holds the duty in PWM mode and the preload otherwise.
    // Duty is used straight from this register, so a change bends the
    // current PWM cycle; buffering it would cost a cycle of latency.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            duty_reg <= `TPM_DUTY_RST;
        end else if (data_wr && (mode == TPM_OP_PWM)) begin
            duty_reg <= req.wdata;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            preload_reg <= `TPM_PRELOAD_RST;
        end else if (data_wr && (mode != TPM_OP_PWM)) begin
            preload_reg <= req.wdata;
        end
    end

    // Counter next value: reload on overflow, step on each prescaled tick, load
    // a data write directly while stopped, otherwise hold the last value for software.
    always_comb begin
        count_next = count_reg;
        if (overflow) begin
            count_next = preload_reg;
        end else if (count_step) begin
            count_next = count_reg + 8'h01;
        end else if (data_wr && (mode != TPM_OP_PWM) && !run_bit) begin
            count_next = req.wdata;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            count_reg <= `TPM_COUNT_RST;
        end else begin
            count_reg <= count_next;
        end
    end

    // Overflow events, one cycle each; sleep turns them into wake requests
    // as well.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            timer_irq_o <= 1'b0;
            wake_req_o <= 1'b0;
        end else begin
            timer_irq_o <= overflow;
            wake_req_o <= overflow && sleep_i;
        end
    end

    // PWM cycle counter of 256 PWM clocks, cleared while disabled.
    // Clearing it on disable makes every enable start at sub-cycle zero.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || !pwm_active) begin
            pwm_cnt_reg <= 8'h00;
        end else if (pwm_tick) begin
            pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
        end
    end

    // Split the cycle into sub-cycles and work out each sub-cycle's high
    // time from the coarse and fine parts of the duty.
    always_comb begin
        if (fmt_sel) begin
            sub_pos = {1'b0, pwm_cnt_reg[6:0]};
            sub_high = {1'b0, duty_reg[7:1]} +
                       {7'h00, (pwm_cnt_reg[7] < duty_reg[0])};
        end else begin
            sub_pos = {2'h0, pwm_cnt_reg[5:0]};
            sub_high = {2'h0, duty_reg[7:2]} +
                       {7'h00, (pwm_cnt_reg[7:6] < duty_reg[1:0])};
        end
    end

    // High from the start of each sub-cycle until its high time is used up.
    assign pwm_high = sub_pos < sub_high;

    // Both outputs come from flops so they switch on the same edge.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            pwm_out_primary_o <= 1'b0;
            pwm_out_inverse_o <= 1'b1;
        end else begin
            pwm_out_primary_o <= pwm_active && pwm_high;
            pwm_out_inverse_o <= !(pwm_active && pwm_high);
        end
    end

    // Read data, valid only in the cycle after the read strobe.
    // Returning zero outside that cycle keeps a shared read bus quiet.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else if (req.rd) begin
            case (req.addr)
                `TPM_OFS_CTRL: reg_rdata_o <= ctrl_reg;
                `TPM_OFS_DATA: begin
                    reg_rdata_o <= (mode == TPM_OP_PWM) ? duty_reg : count_reg;
                end
                `TPM_OFS_STAT: begin
                    reg_rdata_o <= {5'h00, state_reg};
                end
                default: reg_rdata_o <= 8'h00;
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

endmodule

`default_nettype wire
